/* hdl/lpm_ctrl.sv */
`timescale 1ns/1ns

// Contract
// - Sleep stops only the processor clock; peripheral clocks keep running.
// - Sleep ends on any interrupt request or any wake event.
// - Stop puts flash in low power and turns off the PLL and both fast oscillators, keeping SRAM.
// - Stop ends on any interrupt line event (16 pins, voltage monitor, alarm, ethernet, usb), reset pin or watchdog reset.
// - Standby turns off the main regulator, keeps the low-power one, and unpowers logic and flash.
// - Waking from standby raises a system reset and sets the standby-occurred flag together.
// - The standby-occurred flag stays set until software writes the clear bit.
// - Standby keeps the backup registers and, if configured beforehand, 32KB of SRAM.
// - Standby ends on a wake pin rising edge, reset pin, watchdog reset or an interrupt line event; the code leaves out the voltage monitor line.
// - After any wake the internal RC oscillator becomes the system clock; the code keeps the running source after a sleep wake.
// - The 42 backup registers of 16 bits survive standby wake, system reset and power reset.
module lpm_ctrl (
  input  wire logic                                  REF_CLK,
  input  wire logic                                  RST_N,
  input  wire logic                                  POR_N,
  input  wire logic                                  WAIT_ENTER,
  input  wire lpm_pkg::lpm_sel_t                     MODE_SEL,
  input  wire logic                                  SRAM_KEEP_SEL,
  input  wire logic [1:0]                            CLK_SRC_REQ,
  input  wire logic                                  CLK_SRC_WR,
  input  wire logic                                  IRQ_PENDING,
  input  wire logic                                  WAKE_EVENT,
  input  wire logic [lpm_pkg::LPM_GPIO_LINES-1:0]    EXT_LINE,
  input  wire logic                                  VMON_LINE,
  input  wire logic                                  ALARM_LINE,
  input  wire logic                                  ETH_WAKE_LINE,
  input  wire logic                                  USB_WAKE_LINE,
  input  wire logic                                  EXTERNAL_RESET_PIN_N,
  input  wire logic                                  WATCHDOG_RESET,
  input  wire logic                                  WAKE_PIN,
  input  wire logic                                  CLEAR_STANDBY_FLAG_BIT,
  input  wire logic                                  BKP_WR,
  input  wire logic [lpm_pkg::LPM_BKP_AW-1:0]        BKP_ADDR,
  input  wire logic [lpm_pkg::LPM_BKP_WIDTH-1:0]     BKP_WDATA,
  output logic [lpm_pkg::LPM_BKP_WIDTH-1:0]          BKP_RDATA,
  output logic                                       CPU_CLK_EN,
  output logic                                       PERIPH_CLK_EN,
  output logic                                       FLASH_LOW_POWER,
  output logic                                       FLASH_POWER_EN,
  output logic                                       PLL_EN,
  output logic                                       INT_RC_EN,
  output logic                                       CRYSTAL_EN,
  output logic                                       MAIN_REG_EN,
  output logic                                       LP_REG_EN,
  output logic                                       LOGIC_POWER_EN,
  output logic                                       SRAM_RETAIN,
  output logic [1:0]                                 SYS_CLK_SEL,
  output logic                                       SYS_RESET,
  output logic                                       STANDBY_OCCURRED_FLAG
);

  // whole state of the block; backup array kept apart since it survives power reset
  typedef struct packed {
    lpm_pkg::lpm_state_t state;
    logic                wake_pin_prev;
    logic                sram_keep;
    logic [1:0]          clk_sel;
    logic [1:0]          rst_cnt;
    logic                sby_flag;
    logic [lpm_pkg::LPM_BKP_WIDTH-1:0] rdata;
  } lpm_regs_t;

  lpm_regs_t r_q;
  lpm_regs_t r_d;
  logic [lpm_pkg::LPM_BKP_WIDTH-1:0] bkp_mem [lpm_pkg::LPM_BKP_REGS];

  logic line_evt;
  logic pin_rise;
  logic hard_rst;
  logic sleep_wake;
  logic stop_wake;
  logic sby_wake;

  // the two deep modes, where the fast oscillators and the pll must be off
  function automatic logic deep_mode(input lpm_pkg::lpm_state_t st);
    deep_mode = (st == lpm_pkg::LPM_STOP) || (st == lpm_pkg::LPM_STANDBY);
  endfunction

  // no power is left for the core logic, the flash or the main regulator
  function automatic logic unpowered(input lpm_pkg::lpm_state_t st);
    unpowered = (st == lpm_pkg::LPM_STANDBY);
  endfunction

  // only implemented backup words answer; the rest of the address space reads zero
  function automatic logic bkp_addr_ok(input logic [lpm_pkg::LPM_BKP_AW-1:0] addr);
    bkp_addr_ok = (addr < 6'(lpm_pkg::LPM_BKP_REGS));
  endfunction

  // any interrupt-line event that can end stop
  assign line_evt = (|EXT_LINE) | VMON_LINE | ALARM_LINE | ETH_WAKE_LINE | USB_WAKE_LINE;
  // edge taken against last cycle's sample, so a pin held high wakes only once
  assign pin_rise = WAKE_PIN & ~r_q.wake_pin_prev;
  // reset pin low or watchdog firing; both end stop and standby
  assign hard_rst = ~EXTERNAL_RESET_PIN_N | WATCHDOG_RESET;

  // sleep ends on interrupts, wake events and line events alike
  assign sleep_wake = IRQ_PENDING || WAKE_EVENT || line_evt;
  assign stop_wake  = line_evt || hard_rst;
  // voltage monitor is not a standby wake source, so the line set is rebuilt without it
  assign sby_wake   = pin_rise || hard_rst || (|EXT_LINE) || ALARM_LINE || ETH_WAKE_LINE
                      || USB_WAKE_LINE;

  // next-state logic
  always_comb begin
    r_d               = r_q;
    r_d.wake_pin_prev = WAKE_PIN;
    r_d.rdata         = bkp_addr_ok(BKP_ADDR) ? bkp_mem[BKP_ADDR] : 16'h0000;
    // wake reset counts down to zero and then rests there
    if (r_q.rst_cnt != 2'h0) begin
      r_d.rst_cnt = r_q.rst_cnt - 2'h1;
    end
    // a clock source write only takes effect while running; one during a low-power mode is dropped
    if (CLK_SRC_WR && (r_q.state == lpm_pkg::LPM_RUN)) begin
      r_d.clk_sel = CLK_SRC_REQ;
    end
    // clear first so a standby wake in the same cycle still wins
    if (CLEAR_STANDBY_FLAG_BIT) begin
      r_d.sby_flag = 1'b0;
    end
    // entry is taken only from run; each low-power state watches its own wake set
    unique case (r_q.state)
      lpm_pkg::LPM_RUN: begin
        if (WAIT_ENTER) begin
          unique case (MODE_SEL)
            lpm_pkg::LPM_SEL_STOP: r_d.state = lpm_pkg::LPM_STOP;
            lpm_pkg::LPM_SEL_STANDBY: begin
              r_d.state     = lpm_pkg::LPM_STANDBY;
              r_d.sram_keep = SRAM_KEEP_SEL;
            end
            default: r_d.state = lpm_pkg::LPM_SLEEP;
          endcase
        end
      end
      lpm_pkg::LPM_SLEEP: begin
        // clock select is left alone, sleep keeps the source that was running
        if (sleep_wake) begin
          r_d.state = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_STOP: begin
        // deep mode turned off all oscillators, rc included, so the rc oscillator is the one brought back as clock
        if (stop_wake) begin
          r_d.state   = lpm_pkg::LPM_RUN;
          r_d.clk_sel = lpm_pkg::LPM_CLK_INT_RC;
        end
      end
      lpm_pkg::LPM_STANDBY: begin
        // wake reset and flag start in the same cycle so software always sees both
        if (sby_wake) begin
          r_d.state     = lpm_pkg::LPM_RUN;
          r_d.clk_sel   = lpm_pkg::LPM_CLK_INT_RC;
          r_d.rst_cnt   = lpm_pkg::LPM_RST_CYCLES;
          r_d.sby_flag  = 1'b1;
          r_d.sram_keep = 1'b0;
        end
      end
      default: r_d.state = lpm_pkg::LPM_RUN;
    endcase
    // system reset returns clock to the internal oscillator, flag survives
    if (!RST_N) begin
      r_d.state   = lpm_pkg::LPM_RUN;
      r_d.clk_sel = lpm_pkg::LPM_CLK_INT_RC;
      r_d.rst_cnt = 2'h0;
    end
  end

  // flag is only lost on power reset, so software can still read it after the wake reset
  always_ff @(posedge REF_CLK) begin
    if (!POR_N) begin
      r_q <= '{state: lpm_pkg::LPM_RUN, clk_sel: lpm_pkg::LPM_CLK_INT_RC, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // backup store has no reset: contents outlive every kind of reset
  always_ff @(posedge REF_CLK) begin
    if (BKP_WR && (r_q.state == lpm_pkg::LPM_RUN) && bkp_addr_ok(BKP_ADDR)) begin
      bkp_mem[BKP_ADDR] <= BKP_WDATA;
    end
  end

  // power and clock controls decoded from the state
  always_comb begin
    // clock gating: sleep stops only the core
    CPU_CLK_EN      = (r_q.state == lpm_pkg::LPM_RUN);
    PERIPH_CLK_EN   = (r_q.state == lpm_pkg::LPM_RUN) || (r_q.state == lpm_pkg::LPM_SLEEP);

    // flash: low power in stop, unpowered in standby
    FLASH_LOW_POWER = (r_q.state == lpm_pkg::LPM_STOP);
    FLASH_POWER_EN  = ~unpowered(r_q.state);

    // oscillators; the pll is assumed fed from the crystal, so the crystal follows it
    PLL_EN          = ~deep_mode(r_q.state) && (r_q.clk_sel == lpm_pkg::LPM_CLK_PLL);
    INT_RC_EN       = ~deep_mode(r_q.state);
    CRYSTAL_EN      = PLL_EN || (INT_RC_EN && (r_q.clk_sel == lpm_pkg::LPM_CLK_CRYSTAL));

    // supplies: the low-power regulator never drops, it feeds the wake circuit
    MAIN_REG_EN     = ~unpowered(r_q.state);
    LP_REG_EN       = 1'b1;
    LOGIC_POWER_EN  = ~unpowered(r_q.state);
    SRAM_RETAIN     = ~unpowered(r_q.state) || r_q.sram_keep;

    // status seen by software
    SYS_CLK_SEL     = r_q.clk_sel;
    SYS_RESET       = (r_q.rst_cnt != 2'h0);
    STANDBY_OCCURRED_FLAG = r_q.sby_flag;
    BKP_RDATA       = r_q.rdata;
  end

endmodule

/* shared/lpm_pkg.sv */
package lpm_pkg;

  // low-power mode selection, as software sets it before the wait instruction
  typedef enum logic [1:0] {
    LPM_SEL_SLEEP   = 2'h0,
    LPM_SEL_STOP    = 2'h1,
    LPM_SEL_STANDBY = 2'h2
  } lpm_sel_t;

  // controller states, one-hot
  typedef enum logic [3:0] {
    LPM_RUN     = 4'h1,
    LPM_SLEEP   = 4'h2,
    LPM_STOP    = 4'h4,
    LPM_STANDBY = 4'h8
  } lpm_state_t;

  // system clock source selections
  localparam logic [1:0] LPM_CLK_INT_RC   = 2'h0;
  localparam logic [1:0] LPM_CLK_CRYSTAL  = 2'h1;
  localparam logic [1:0] LPM_CLK_PLL      = 2'h2;

  localparam int unsigned LPM_GPIO_LINES  = 16;
  localparam int unsigned LPM_BKP_REGS    = 42;
  localparam int unsigned LPM_BKP_WIDTH   = 16;
  localparam int unsigned LPM_BKP_AW      = 6;
  localparam int unsigned LPM_SRAM_KB     = 32;

  // wake reset pulse length in clock cycles
  localparam logic [1:0]  LPM_RST_CYCLES  = 2'h2;

endpackage

/* verification/low_power_mode_controller_bench.sv */
`timescale 1ns/1ns
module low_power_mode_controller_bench;
  logic REF_CLK = 1'b0, RST_N = 1'b0, POR_N = 1'b0, WAIT_ENTER = 1'b0, SRAM_KEEP_SEL = 1'b0;
  logic CLK_SRC_WR = 1'b0, IRQ_PENDING = 1'b0, WAKE_EVENT = 1'b0, BKP_WR = 1'b0, fire = 1'b0;
  logic CLEAR_STANDBY_FLAG_BIT = 1'b0, VMON_LINE, ALARM_LINE, ETH_WAKE_LINE, USB_WAKE_LINE;
  logic [1:0] CLK_SRC_REQ = 2'h0, SYS_CLK_SEL;
  logic [2:0] src = 3'h0;
  logic [5:0] BKP_ADDR = 6'h29;
  logic [15:0] BKP_WDATA = 16'ha5c3, EXT_LINE, BKP_RDATA;
  lpm_pkg::lpm_sel_t MODE_SEL = lpm_pkg::LPM_SEL_SLEEP;
  logic EXTERNAL_RESET_PIN_N, WATCHDOG_RESET, WAKE_PIN, CPU_CLK_EN, PERIPH_CLK_EN, PLL_EN;
  logic FLASH_LOW_POWER, FLASH_POWER_EN, INT_RC_EN, CRYSTAL_EN, MAIN_REG_EN, LP_REG_EN;
  logic LOGIC_POWER_EN, SRAM_RETAIN, SYS_RESET, STANDBY_OCCURRED_FLAG;
  int n_errors = 0;
  int n_checks = 0;
  always #4 REF_CLK = ~REF_CLK;
  lpm_ctrl lpm_ctrl_inst (.*);
  lpm_wake_model lpm_wake_model_inst (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // select the pll before each entry so the wake fallback to the rc clock shows
  task enter(input lpm_pkg::lpm_sel_t m, input logic keep);
    @(posedge REF_CLK);
    {CLK_SRC_REQ, CLK_SRC_WR} <= 3'h5;
    @(posedge REF_CLK);
    {MODE_SEL, WAIT_ENTER, SRAM_KEEP_SEL, CLK_SRC_WR} <= {m, 1'b1, keep, 1'b0};
    @(posedge REF_CLK);
    WAIT_ENTER <= 1'b0;
    #1;
  endtask
  task wake(input logic [2:0] s);
    @(posedge REF_CLK);
    {src, fire} <= {s, 1'b1};
    @(posedge REF_CLK);
    fire <= 1'b0;
    @(posedge REF_CLK);
    #1;
  endtask
  task t_sleep;
    for (int i = 0; i < 2; i++) begin
      enter(lpm_pkg::LPM_SEL_SLEEP, 1'b0);
      chk({CPU_CLK_EN, PERIPH_CLK_EN}, 16'h0001);
      @(posedge REF_CLK);
      {IRQ_PENDING, WAKE_EVENT} <= (i == 0) ? 2'h2 : 2'h1;
      @(posedge REF_CLK);
      {IRQ_PENDING, WAKE_EVENT} <= 2'h0;
      #1;
      chk({CPU_CLK_EN, SYS_CLK_SEL}, 16'h0006);
    end
    $display("sleep test done");
  endtask
  // crystal select, mode code 3 acting as sleep, and a clock write refused while asleep
  task t_refuse;
    @(posedge REF_CLK);
    {CLK_SRC_REQ, CLK_SRC_WR} <= 3'h3;
    @(posedge REF_CLK);
    CLK_SRC_WR <= 1'b0;
    #1;
    chk({PLL_EN, CRYSTAL_EN, INT_RC_EN, SYS_CLK_SEL}, 16'h000d);
    enter(lpm_pkg::lpm_sel_t'(2'h3), 1'b0);
    chk({CPU_CLK_EN, PERIPH_CLK_EN, FLASH_LOW_POWER}, 16'h0002);
    @(posedge REF_CLK);
    {CLK_SRC_REQ, CLK_SRC_WR, IRQ_PENDING} <= 4'h3;
    @(posedge REF_CLK);
    {CLK_SRC_WR, IRQ_PENDING} <= 2'h0;
    #1;
    chk({CPU_CLK_EN, SYS_CLK_SEL}, 16'h0006);
    $display("refuse test done");
  endtask
  // every stop source in turn; reset pin and watchdog wake without a reset pulse
  task t_stop;
    for (int s = 0; s < 7; s++) begin
      enter(lpm_pkg::LPM_SEL_STOP, 1'b0);
      chk({FLASH_LOW_POWER, PLL_EN, INT_RC_EN, CRYSTAL_EN, SRAM_RETAIN}, 16'h0011);
      wake(s[2:0]);
      chk({CPU_CLK_EN, SYS_CLK_SEL, SYS_RESET}, 16'h0008);
    end
    $display("stop test done");
  endtask
  task t_stby;
    for (int s = 0; s < 8; s++) if (s != 1) begin
      enter(lpm_pkg::LPM_SEL_STANDBY, s[0]);
      chk({MAIN_REG_EN, LP_REG_EN, LOGIC_POWER_EN, FLASH_POWER_EN}, 16'h0004);
      chk(SRAM_RETAIN, s[0]);
      wake(s[2:0]);
      chk({SYS_RESET, STANDBY_OCCURRED_FLAG, SYS_CLK_SEL}, 16'h000c);
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'b0;
      @(posedge REF_CLK);
      {RST_N, CLEAR_STANDBY_FLAG_BIT} <= 2'h3;
      #1;
      chk({SYS_RESET, STANDBY_OCCURRED_FLAG}, 16'h0001);
      @(posedge REF_CLK);
      CLEAR_STANDBY_FLAG_BIT <= 1'b0;
      #1;
      chk(STANDBY_OCCURRED_FLAG, 16'h0000);
      chk(BKP_RDATA, 16'ha5c3);
    end
    $display("standby test done");
  endtask
  // the backup word is written once and must survive every wake, reset and power reset
  initial begin
    repeat (3) @(posedge REF_CLK);
    {POR_N, RST_N, BKP_WR} <= 3'h7;
    @(posedge REF_CLK);
    BKP_WR <= 1'b0;
    t_sleep;
    t_refuse;
    t_stop;
    t_stby;
    POR_N <= 1'b0;
    @(posedge REF_CLK);
    POR_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1;
    chk(STANDBY_OCCURRED_FLAG, 16'h0000);
    chk(BKP_RDATA, 16'ha5c3);
    test_done;
  end
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule

/* verification/lpm_ctrl_assertions.sv */
`timescale 1ns/1ns
module lpm_ctrl_checker (
  input wire logic REF_CLK, RST_N, POR_N, WAIT_ENTER, SRAM_KEEP_SEL, IRQ_PENDING, WAKE_EVENT,
  input wire lpm_pkg::lpm_sel_t MODE_SEL,
  input wire logic [15:0] EXT_LINE,
  input wire logic WAKE_PIN, CLEAR_STANDBY_FLAG_BIT, CPU_CLK_EN, PERIPH_CLK_EN, PLL_EN,
  input wire logic FLASH_LOW_POWER, INT_RC_EN, CRYSTAL_EN, MAIN_REG_EN, LP_REG_EN,
  input wire logic LOGIC_POWER_EN, FLASH_POWER_EN, SRAM_RETAIN, SYS_RESET, STANDBY_OCCURRED_FLAG,
  input wire logic [1:0] SYS_CLK_SEL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!POR_N || !RST_N);
  // sleep is the only state with the core stopped but main power and fast flash up
  wire slp = !CPU_CLK_EN && MAIN_REG_EN && !FLASH_LOW_POWER;
  property p_slp; WAIT_ENTER && CPU_CLK_EN && MODE_SEL == lpm_pkg::LPM_SEL_SLEEP
    |=> !CPU_CLK_EN && PERIPH_CLK_EN && $stable(SYS_CLK_SEL); endproperty
  a_slp: assert property (p_slp) else $error("sleep entry wrong");
  property p_swk; slp && (IRQ_PENDING || WAKE_EVENT) |=> CPU_CLK_EN; endproperty
  a_swk: assert property (p_swk) else $error("sleep did not end");
  property p_stp; WAIT_ENTER && CPU_CLK_EN && MODE_SEL == lpm_pkg::LPM_SEL_STOP
    |=> FLASH_LOW_POWER && !PLL_EN && !INT_RC_EN && !CRYSTAL_EN && SRAM_RETAIN; endproperty
  a_stp: assert property (p_stp) else $error("stop entry wrong");
  property p_pwk; FLASH_LOW_POWER && |EXT_LINE
    |=> CPU_CLK_EN && SYS_CLK_SEL == lpm_pkg::LPM_CLK_INT_RC; endproperty
  a_pwk: assert property (p_pwk) else $error("stop wake wrong");
  property p_sby; WAIT_ENTER && CPU_CLK_EN && MODE_SEL == lpm_pkg::LPM_SEL_STANDBY
    |=> !MAIN_REG_EN && LP_REG_EN && !LOGIC_POWER_EN && !FLASH_POWER_EN
    && SRAM_RETAIN == $past(SRAM_KEEP_SEL); endproperty
  a_sby: assert property (p_sby) else $error("standby entry wrong");
  property p_bwk; !MAIN_REG_EN && WAKE_PIN && !$past(WAKE_PIN)
    |=> SYS_RESET && STANDBY_OCCURRED_FLAG ##1 SYS_RESET ##1 !SYS_RESET; endproperty
  a_bwk: assert property (p_bwk) else $error("standby wake wrong");
  property p_fkp; STANDBY_OCCURRED_FLAG && !CLEAR_STANDBY_FLAG_BIT |=> STANDBY_OCCURRED_FLAG;
  endproperty
  a_fkp: assert property (p_fkp) else $error("flag dropped");
  property p_fcl; CLEAR_STANDBY_FLAG_BIT && CPU_CLK_EN |=> !STANDBY_OCCURRED_FLAG; endproperty
  a_fcl: assert property (p_fcl) else $error("flag not cleared");
  cover property (slp ##1 CPU_CLK_EN);
  cover property ($rose(SYS_RESET));
  cover property ($fell(STANDBY_OCCURRED_FLAG));
endmodule
bind lpm_ctrl lpm_ctrl_checker lpm_ctrl_checker_inst (.*);

/* verification/lpm_wake_model.sv */
`timescale 1ns/1ns
module lpm_wake_model (
  input wire logic REF_CLK, fire,
  input wire logic [2:0] src,
  output logic [15:0] EXT_LINE,
  output logic VMON_LINE, ALARM_LINE, ETH_WAKE_LINE, USB_WAKE_LINE,
  output logic EXTERNAL_RESET_PIN_N, WATCHDOG_RESET, WAKE_PIN
);
  logic [7:0] hit_q = 8'h00;
  // one registered pulse per request; sources idle inactive, the reset pin idles high
  always @(posedge REF_CLK) hit_q <= fire ? 8'h01 << src : 8'h00;
  assign EXT_LINE = {hit_q[0], 15'h0000};
  assign {WAKE_PIN, WATCHDOG_RESET, USB_WAKE_LINE, ETH_WAKE_LINE} = {hit_q[7:6], hit_q[4:3]};
  assign {ALARM_LINE, VMON_LINE, EXTERNAL_RESET_PIN_N} = {hit_q[2:1], ~hit_q[5]};
endmodule
